// *** common/bod_pkg.sv ***
// package: opcode fields, encodings and cycle constants for the instruction decoder
package bod_pkg;
   localparam int unsigned INSTR_W        = 14;
   localparam int unsigned ADDR_W         = 7;
   localparam int unsigned OSC_PER_CYCLE  = 4;
   localparam logic [1:0]  PHASE_LAST     = 2'h3;
   // field positions
   localparam int unsigned ADDR_LSB       = 0;
   localparam int unsigned DEST_POS       = 7;
   localparam int unsigned BIT_LSB        = 7;
   localparam int unsigned OP6_LSB        = 8;
   localparam int unsigned OP4_LSB        = 10;
   localparam int unsigned BRA_LSB        = 9;
   localparam int unsigned CALL_LSB       = 11;
   localparam int unsigned IDX_FSR_POS    = 6;
   localparam int unsigned IDX_MOVI_POS   = 2;
   localparam int unsigned FSR_PROG_BIT   = 15;
   // indirect file register addresses
   localparam logic [6:0]  INDF0_ADDR     = 7'h00;
   localparam logic [6:0]  INDF1_ADDR     = 7'h01;
   // byte-oriented opcodes, bits 13:8
   localparam logic [5:0]  OP_ADD_W_TO_FILE       = 6'h07;
   localparam logic [5:0]  OP_ADD_W_CARRY_TO_FILE = 6'h3D;
   localparam logic [5:0]  OP_AND_W_WITH_FILE     = 6'h05;
   localparam logic [5:0]  OP_OR_W_WITH_FILE      = 6'h04;
   localparam logic [5:0]  OP_ROTATE_LEFT         = 6'h0D;
   localparam logic [5:0]  OP_ROTATE_RIGHT        = 6'h0C;
   localparam logic [5:0]  OP_XOR_W_WITH_FILE     = 6'h06;
   localparam logic [5:0]  OP_SUB_W_FROM_FILE     = 6'h02;
   localparam logic [5:0]  OP_SUB_W_BORROW        = 6'h3B;
   localparam logic [5:0]  OP_SWAP_NIBBLES        = 6'h0E;
   localparam logic [5:0]  OP_ARITH_SHIFT_RIGHT   = 6'h37;
   localparam logic [5:0]  OP_LOGIC_SHIFT_LEFT    = 6'h35;
   localparam logic [5:0]  OP_LOGIC_SHIFT_RIGHT   = 6'h36;
   localparam logic [5:0]  OP_CLEAR               = 6'h01;
   localparam logic [5:0]  OP_COMPLEMENT          = 6'h09;
   localparam logic [5:0]  OP_DECREMENT           = 6'h03;
   localparam logic [5:0]  OP_INCREMENT           = 6'h0A;
   localparam logic [5:0]  OP_MOVE_FILE           = 6'h08;
   localparam logic [5:0]  OP_DECREMENT_SKIP_ZERO = 6'h0B;
   localparam logic [5:0]  OP_INCREMENT_SKIP_ZERO = 6'h0F;
   localparam logic [5:0]  OP_MOVE_INDEXED        = 6'h3F;
   localparam logic [5:0]  OP_SPECIAL             = 6'h00;
   localparam logic [5:0]  OP_RETURN_WITH_LITERAL = 6'h34;
   // bit-oriented opcodes, bits 13:10
   localparam logic [3:0]  OP_BIT_CLEAR           = 4'h4;
   localparam logic [3:0]  OP_BIT_SET             = 4'h5;
   localparam logic [3:0]  OP_SKIP_IF_BIT_CLEAR   = 4'h6;
   localparam logic [3:0]  OP_SKIP_IF_BIT_SET     = 4'h7;
   // control opcodes
   localparam logic [4:0]  OP_RELATIVE_BRANCH     = 5'h19;
   localparam logic [2:0]  OP_SUBROUTINE_CALL     = 3'h4;
   localparam logic [2:0]  OP_ABSOLUTE_JUMP       = 3'h5;
   localparam logic [13:0] OP_RETURN              = 14'h0008;
   localparam logic [13:0] OP_INTERRUPT_RETURN    = 14'h0009;
   localparam logic [13:0] OP_CALL_VIA_W          = 14'h000A;
   localparam logic [13:0] OP_BRANCH_VIA_W        = 14'h000B;
   localparam logic [9:0]  OP_MOVE_FSR_HI         = 10'h001;
   // alu operation select
   typedef enum logic [3:0] {
      BOD_ALU_PASS  = 4'h0,
      BOD_ALU_ADD   = 4'h1,
      BOD_ALU_ADDC  = 4'h2,
      BOD_ALU_AND   = 4'h3,
      BOD_ALU_OR    = 4'h4,
      BOD_ALU_RLC   = 4'h5,
      BOD_ALU_RRC   = 4'h6,
      BOD_ALU_XOR   = 4'h7,
      BOD_ALU_SUB   = 4'h8,
      BOD_ALU_SUBB  = 4'h9,
      BOD_ALU_SWAP  = 4'hA,
      BOD_ALU_ASR   = 4'hB,
      BOD_ALU_LSL   = 4'hC,
      BOD_ALU_LSR   = 4'hD,
      BOD_ALU_CLR   = 4'hE,
      BOD_ALU_COM   = 4'hF
   } bod_alu_t;
   // sequencer states, gray along the idle-exec-extra-flush path
   typedef enum logic [1:0] {
      BOD_ST_IDLE  = 2'b00,
      BOD_ST_EXEC  = 2'b01,
      BOD_ST_EXTRA = 2'b11,
      BOD_ST_FLUSH = 2'b10
   } bod_state_t;
endpackage : bod_pkg

// *** verilog/bod_phase_div.sv ***
// four-phase divider giving one instruction cycle per four oscillator clocks
`timescale 1ns/10ps
module bod_phase_div
#(
   parameter int unsigned DIV = 4
)
(
   input  wire logic       sys_clk_i,
   input  wire logic       rst_n_i,
   output logic [1:0]      phase_o,
   output logic            cycle_end_o
);
   import bod_pkg::*;

   // free-running phase counter, wraps after DIV clocks
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         phase_o <= 2'h0;
      end
      else if (phase_o == 2'(DIV - 1))
      begin
         phase_o <= 2'h0;
      end
      else
      begin
         phase_o <= phase_o + 2'h1;
      end
   end

   // end-of-cycle enable pulse
   assign cycle_end_o = (phase_o == 2'(DIV - 1));
endmodule : bod_phase_div

// *** verilog/bod_decoder.sv ***
// instruction decoder and cycle sequencer for the 8-bit core
`timescale 1ns/10ps
module bod_decoder
#(
   parameter int unsigned IW = 14,
   parameter int unsigned AW = 7
)
(
   input  wire logic               sys_clk_i,
   input  wire logic               rst_n_i,
   input  wire logic [IW-1:0]      instr_i,
   input  wire logic               instr_valid_i,
   input  wire logic [7:0]         file_rdata_i,
   input  wire logic [7:0]         w_i,
   input  wire logic               carry_i,
   input  wire logic [15:0]        fsr0_i,
   input  wire logic [15:0]        fsr1_i,
   input  wire logic               skip_cond_i,
   output logic                    instr_ready_o,
   output logic [1:0]              phase_o,
   output logic                    file_rd_o,
   output logic                    file_wr_o,
   output logic [AW-1:0]           file_addr_o,
   output logic [7:0]              file_wdata_o,
   output logic                    w_wr_o,
   output logic [7:0]              w_wdata_o,
   output logic                    flags_wr_o,
   output logic [2:0]              flags_mask_o,
   output logic [2:0]              flags_o,
   output logic [2:0]              bit_sel_o,
   output logic                    fsr_index_o,
   output logic [7:0]              literal_o,
   output logic                    flow_change_o,
   output logic                    illegal_o,
   output logic                    done_o,
   output logic [1:0]              cycles_o
);
   import bod_pkg::*;

   // flag bit positions inside flags_o and flags_mask_o
   localparam int unsigned FL_C  = 0;
   localparam int unsigned FL_DC = 1;
   localparam int unsigned FL_Z  = 2;

   bod_state_t          state_reg;
   bod_state_t          state_next;
   logic                cycle_end;
   logic [IW-1:0]       ir_reg;
   logic [1:0]          cnt_reg;
   logic [1:0]          need_reg;
   logic [1:0]          need_now;
   bod_alu_t            alu_op;
   logic                uses_file;
   logic                writes_only;
   logic                flow_always;
   logic                skip_type;
   logic                known;
   logic [2:0]          fmask;
   logic                indirect_file_register_hit;
   logic                fsr_prog;
   logic                dest_bit;
   logic [5:0]          op6;
   logic [3:0]          op4;
   logic [8:0]          sum;
   logic [4:0]          nib;
   logic [7:0]          res;
   logic                c_out;
   logic                dc_out;
   logic                cin;

   bod_phase_div #(.DIV(OSC_PER_CYCLE)) u_phase
   (
      .sys_clk_i   (sys_clk_i),
      .rst_n_i     (rst_n_i),
      .phase_o     (phase_o),
      .cycle_end_o (cycle_end)
   );

   assign op6      = ir_reg[OP6_LSB +: 6];
   assign op4      = ir_reg[OP4_LSB +: 4];
   assign dest_bit = ir_reg[DEST_POS];

   always_comb
   begin
      alu_op      = BOD_ALU_PASS;
      uses_file   = 1'b0;
      writes_only = 1'b0;
      flow_always = 1'b0;
      skip_type   = 1'b0;
      known       = 1'b1;
      fmask       = 3'h0;
      if (op4 == OP_BIT_CLEAR || op4 == OP_BIT_SET)
      begin
         uses_file = 1'b1;
      end
      else if (op4 == OP_SKIP_IF_BIT_CLEAR || op4 == OP_SKIP_IF_BIT_SET)
      begin
         uses_file = 1'b1;
         skip_type = 1'b1;
      end
      else if (ir_reg[13:11] == OP_SUBROUTINE_CALL || ir_reg[13:11] == OP_ABSOLUTE_JUMP)
      begin
         flow_always = 1'b1;
      end
      else if (ir_reg[13:9] == OP_RELATIVE_BRANCH)
      begin
         flow_always = 1'b1;
      end
      else if (op6 == OP_RETURN_WITH_LITERAL)
      begin
         flow_always = 1'b1;
      end
      else if (ir_reg == OP_RETURN || ir_reg == OP_INTERRUPT_RETURN)
      begin
         flow_always = 1'b1;
      end
      else if (ir_reg == OP_CALL_VIA_W || ir_reg == OP_BRANCH_VIA_W)
      begin
         flow_always = 1'b1;
      end
      else if (ir_reg[13:4] == OP_MOVE_FSR_HI || op6 == OP_MOVE_INDEXED)
      begin
         uses_file = 1'b1;
      end
      else if (op6 == OP_SPECIAL || (ir_reg[13:12] == 2'h3 && op6 != OP_ADD_W_CARRY_TO_FILE
               && op6 != OP_SUB_W_BORROW && op6 != OP_ARITH_SHIFT_RIGHT
               && op6 != OP_LOGIC_SHIFT_LEFT && op6 != OP_LOGIC_SHIFT_RIGHT))
      begin
         // remaining literal and inherent forms pass straight through; file ops of the 11 group go on
         known = 1'b1;
      end
      else
      begin
         uses_file = 1'b1;
         case (op6)
            OP_ADD_W_TO_FILE:       begin alu_op = BOD_ALU_ADD;  fmask = 3'h7; end
            OP_ADD_W_CARRY_TO_FILE: begin alu_op = BOD_ALU_ADDC; fmask = 3'h7; end
            OP_AND_W_WITH_FILE:     begin alu_op = BOD_ALU_AND;  fmask = 3'h4; end
            OP_OR_W_WITH_FILE:      begin alu_op = BOD_ALU_OR;   fmask = 3'h4; end
            OP_XOR_W_WITH_FILE:     begin alu_op = BOD_ALU_XOR;  fmask = 3'h4; end
            OP_ROTATE_LEFT:         begin alu_op = BOD_ALU_RLC;  fmask = 3'h1; end
            OP_ROTATE_RIGHT:        begin alu_op = BOD_ALU_RRC;  fmask = 3'h1; end
            OP_SUB_W_FROM_FILE:     begin alu_op = BOD_ALU_SUB;  fmask = 3'h7; end
            OP_SUB_W_BORROW:        begin alu_op = BOD_ALU_SUBB; fmask = 3'h7; end
            OP_SWAP_NIBBLES:        begin alu_op = BOD_ALU_SWAP; end
            OP_ARITH_SHIFT_RIGHT:   begin alu_op = BOD_ALU_ASR;  fmask = 3'h5; end
            OP_LOGIC_SHIFT_LEFT:    begin alu_op = BOD_ALU_LSL;  fmask = 3'h5; end
            OP_LOGIC_SHIFT_RIGHT:   begin alu_op = BOD_ALU_LSR;  fmask = 3'h5; end
            OP_COMPLEMENT:          begin alu_op = BOD_ALU_COM;  fmask = 3'h4; end
            OP_DECREMENT:           begin alu_op = BOD_ALU_SUB;  fmask = 3'h4; end
            OP_INCREMENT:           begin alu_op = BOD_ALU_ADD;  fmask = 3'h4; end
            OP_MOVE_FILE:           begin alu_op = BOD_ALU_PASS; fmask = 3'h4; end
            OP_CLEAR:               begin alu_op = BOD_ALU_CLR;  fmask = 3'h4; writes_only = dest_bit; end
            OP_DECREMENT_SKIP_ZERO: begin alu_op = BOD_ALU_SUB;  skip_type = 1'b1; end
            OP_INCREMENT_SKIP_ZERO: begin alu_op = BOD_ALU_ADD;  skip_type = 1'b1; end
            default:                begin known = 1'b0; uses_file = 1'b0; end
         endcase
      end
   end

   assign fsr_index_o = (op6 == OP_MOVE_INDEXED) ? ir_reg[IDX_FSR_POS] :
                        (ir_reg[13:4] == OP_MOVE_FSR_HI) ? ir_reg[IDX_MOVI_POS] :
                        ir_reg[ADDR_LSB +: AW] == INDF1_ADDR;
   // clear-w don't-care bits never look indirect
   assign indirect_file_register_hit = uses_file && !(op6 == OP_CLEAR && !dest_bit)
                     && ((ir_reg[ADDR_LSB +: AW] == INDF0_ADDR) || (ir_reg[ADDR_LSB +: AW] == INDF1_ADDR)
                     || op6 == OP_MOVE_INDEXED || ir_reg[13:4] == OP_MOVE_FSR_HI);
   assign fsr_prog = fsr_index_o ? fsr1_i[FSR_PROG_BIT] : fsr0_i[FSR_PROG_BIT];

   // operand selection for inc/dec uses constant one instead of w
   always_comb
   begin
      logic [7:0] opb;
      opb = (op6 == OP_DECREMENT || op6 == OP_INCREMENT || skip_type) ? 8'h01 : w_i;
      cin = (alu_op == BOD_ALU_ADDC) ? carry_i : (alu_op == BOD_ALU_SUBB) ? carry_i : 1'b1;
      sum    = 9'h000;
      nib    = 5'h00;
      res    = file_rdata_i;
      c_out  = carry_i;
      dc_out = 1'b0;
      case (alu_op)
         BOD_ALU_ADD, BOD_ALU_ADDC:
         begin
            sum    = {1'b0, file_rdata_i} + {1'b0, opb} + {8'h00, (alu_op == BOD_ALU_ADDC) & cin};
            nib    = {1'b0, file_rdata_i[3:0]} + {1'b0, opb[3:0]} + {4'h0, (alu_op == BOD_ALU_ADDC) & cin};
            res    = sum[7:0];
            c_out  = sum[8];
            dc_out = nib[4];
         end
         BOD_ALU_SUB, BOD_ALU_SUBB:
         begin
            sum    = {1'b0, file_rdata_i} + {1'b0, ~opb} + {8'h00, cin};
            nib    = {1'b0, file_rdata_i[3:0]} + {1'b0, ~opb[3:0]} + {4'h0, cin};
            res    = sum[7:0];
            c_out  = sum[8];
            dc_out = nib[4];
         end
         BOD_ALU_AND:  res = file_rdata_i & w_i;
         BOD_ALU_OR:   res = file_rdata_i | w_i;
         BOD_ALU_XOR:  res = file_rdata_i ^ w_i;
         BOD_ALU_RLC:  begin res = {file_rdata_i[6:0], carry_i}; c_out = file_rdata_i[7]; end
         BOD_ALU_RRC:  begin res = {carry_i, file_rdata_i[7:1]}; c_out = file_rdata_i[0]; end
         BOD_ALU_SWAP: res = {file_rdata_i[3:0], file_rdata_i[7:4]};
         BOD_ALU_ASR:  begin res = {file_rdata_i[7], file_rdata_i[7:1]}; c_out = file_rdata_i[0]; end
         BOD_ALU_LSL:  begin res = {file_rdata_i[6:0], 1'b0}; c_out = file_rdata_i[7]; end
         BOD_ALU_LSR:  begin res = {1'b0, file_rdata_i[7:1]}; c_out = file_rdata_i[0]; end
         BOD_ALU_CLR:  res = 8'h00;
         BOD_ALU_COM:  res = ~file_rdata_i;
         default:      res = file_rdata_i;
      endcase
   end

   // sequencer next state
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         BOD_ST_IDLE:  if (cycle_end && instr_valid_i) state_next = BOD_ST_EXEC;
         BOD_ST_EXEC:  if (cycle_end) state_next = (need_now > 2'h1) ? BOD_ST_EXTRA : BOD_ST_FLUSH;
         BOD_ST_EXTRA: if (cycle_end && cnt_reg + 2'h2 >= need_reg) state_next = BOD_ST_FLUSH;
         BOD_ST_FLUSH: state_next = instr_valid_i ? BOD_ST_IDLE : BOD_ST_IDLE;
         default:      state_next = BOD_ST_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i) state_reg <= BOD_ST_IDLE;
      else          state_reg <= state_next;
   end

   // latch instruction word at cycle boundary
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         ir_reg <= '0;
      else if (state_reg == BOD_ST_IDLE && cycle_end && instr_valid_i)
         ir_reg <= instr_i;
   end

   // skip adds a cycle only when taken; extra cycle
   assign need_now = 2'h1 + 2'(flow_always | (skip_type & skip_cond_i)) + 2'(indirect_file_register_hit & fsr_prog);

   // cycle budget; base one, plus flow and indirect extras
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         need_reg <= 2'h1;
         cnt_reg  <= 2'h0;
      end
      else if (state_reg == BOD_ST_EXEC && cycle_end)
      begin
         need_reg <= need_now;
         cnt_reg  <= 2'h0;
      end
      else if (state_reg == BOD_ST_EXTRA && cycle_end)
      begin
         cnt_reg <= cnt_reg + 2'h1;
      end
   end

   // read during execute for file-using ops only, write at cycle end
   assign file_rd_o   = (state_reg == BOD_ST_EXEC) && uses_file;
   assign file_wr_o   = file_rd_o && cycle_end && (dest_bit || writes_only) && alu_op != BOD_ALU_PASS;
   assign w_wr_o      = file_rd_o && cycle_end && !dest_bit && !skip_type && op4[3:2] != 2'h1;
   assign flags_wr_o  = file_rd_o && cycle_end && (fmask != 3'h0);
   assign instr_ready_o = (state_reg == BOD_ST_IDLE) && cycle_end;
   assign file_addr_o = ir_reg[ADDR_LSB +: AW];
   assign bit_sel_o   = ir_reg[BIT_LSB +: 3];
   assign literal_o   = ir_reg[7:0];
   assign flags_mask_o = fmask;

   // registered results
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         file_wdata_o  <= 8'h00;
         w_wdata_o     <= 8'h00;
         flags_o       <= 3'h0;
         flow_change_o <= 1'b0;
         illegal_o     <= 1'b0;
         done_o        <= 1'b0;
         cycles_o      <= 2'h0;
      end
      else
      begin
         done_o <= (state_reg == BOD_ST_FLUSH);
         if (state_reg == BOD_ST_EXEC)
         begin
            file_wdata_o  <= res;
            w_wdata_o     <= res;
            flags_o[FL_C]  <= c_out;
            flags_o[FL_DC] <= dc_out;
            flags_o[FL_Z]  <= (res == 8'h00);
            flow_change_o <= flow_always | (skip_type & skip_cond_i);
            illegal_o     <= ~known;
         end
         if (state_reg == BOD_ST_FLUSH)
            cycles_o <= need_reg;
      end
   end
endmodule : bod_decoder

// *** dv/bod_decoder_asserts.sv ***
// checker: cycle and strobe relations at the decoder ports
`timescale 1ns/10ps
module bod_decoder_asserts
   import bod_pkg::*;
(
   input  wire logic       sys_clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       instr_valid_i,
   input  wire logic       instr_ready_o,
   input  wire logic [1:0] phase_o,
   input  wire logic       file_rd_o,
   input  wire logic       file_wr_o,
   input  wire logic       w_wr_o,
   input  wire logic       flags_wr_o,
   input  wire logic       flow_change_o,
   input  wire logic       done_o,
   input  wire logic [1:0] cycles_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   // phase walk, take window and strobe timing
   a_phase_wrap: assert property (phase_o == PHASE_LAST |=> phase_o == 2'h0)
      else $error("phase did not wrap");
   a_phase_step: assert property (phase_o != PHASE_LAST |=> phase_o == $past(phase_o) + 2'h1)
      else $error("phase did not step");
   a_ready_phase: assert property (instr_ready_o |-> phase_o == PHASE_LAST && !file_rd_o)
      else $error("ready outside last idle phase");
   a_busy_refuse: assert property (instr_ready_o && instr_valid_i |=> !instr_ready_o [*4])
      else $error("ready while executing");
   a_strobe_phase: assert property ((file_wr_o || w_wr_o || flags_wr_o) |-> phase_o == PHASE_LAST)
      else $error("write strobe off last phase");
   a_read_first: assert property (file_wr_o |-> file_rd_o && $past(file_rd_o, 3))
      else $error("file written without read");
   a_one_dest: assert property (file_wr_o |-> !w_wr_o)
      else $error("both destinations written");
   a_done_pulse: assert property (done_o |=> !done_o)
      else $error("done longer than one clock");
   a_flow_two: assert property (done_o && flow_change_o |-> cycles_o >= 2'h2)
      else $error("flow change in one cycle");
   a_done_cycles: assert property (done_o |-> cycles_o != 2'h0)
      else $error("zero cycle count");
   // main scenarios reached
   c_take: cover property (instr_ready_o && instr_valid_i);
   c_two: cover property (done_o && cycles_o == 2'h2);
   c_file_wr: cover property (file_wr_o);
endmodule : bod_decoder_asserts

// *** dv/bod_file_model.sv ***
// partner: data file registers, W and status flags seen by the decoder
`timescale 1ns/10ps
module bod_file_model
(
   input  wire logic       sys_clk_i,
   input  wire logic       file_rd_i,
   input  wire logic       file_wr_i,
   input  wire logic       w_wr_i,
   input  wire logic       flags_wr_i,
   input  wire logic [6:0] file_addr_i,
   input  wire logic [7:0] file_wdata_i,
   input  wire logic [7:0] w_wdata_i,
   input  wire logic [2:0] flags_mask_i,
   input  wire logic [2:0] flags_i,
   output logic      [7:0] file_rdata_o,
   output logic      [7:0] w_o,
   output logic            carry_o
);
   logic [7:0] file_mem [0:127];
   logic [7:0] w_reg;
   logic [2:0] flag_reg;               // {Z,DC,C}
   logic [7:0] last_reg = 8'hA5;
   logic       fw_reg;
   logic       ww_reg;
   logic       gw_reg;
   // read data only
   // unselected read shows the inverse of the last value
   assign file_rdata_o = file_rd_i ? file_mem[file_addr_i] : ~last_reg;
   assign w_o          = w_reg;
   assign carry_o      = flag_reg[0];
   // masked result store
   // strobes come at the last phase, result data is taken one clock later
   always @(posedge sys_clk_i)
   begin
      fw_reg <= file_wr_i;
      ww_reg <= w_wr_i;
      gw_reg <= flags_wr_i;
      if (file_rd_i) last_reg <= file_mem[file_addr_i];
      if (fw_reg) file_mem[file_addr_i] <= file_wdata_i;
      if (ww_reg) w_reg <= w_wdata_i;
      if (gw_reg) flag_reg <= (flag_reg & ~flags_mask_i) | (flags_i & flags_mask_i);
   end
endmodule : bod_file_model

// *** dv/testbench.sv ***
// testbench: decoder against a reference model and the file register partner
`timescale 1ns/10ps
module testbench;
   import bod_pkg::*;
   logic        sys_clk_i, rst_n_i, instr_valid_i, skip_cond_i, carry_i;
   logic [13:0] instr_i;
   logic [15:0] fsr0_i, fsr1_i;
   logic [7:0]  file_rdata_i, w_i, file_wdata_o, w_wdata_o, literal_o;
   logic        instr_ready_o, file_rd_o, file_wr_o, w_wr_o, flags_wr_o;
   logic        fsr_index_o, flow_change_o, illegal_o, done_o;
   logic [1:0]  phase_o, cycles_o;
   logic [6:0]  file_addr_o, addr_seen;
   logic [2:0]  flags_mask_o, flags_o, bit_sel_o, bit_seen;
   logic [31:0] seed = 32'hF858;
   logic [5:0]  ops [6] = '{OP_ADD_W_TO_FILE, OP_ADD_W_CARRY_TO_FILE, OP_AND_W_WITH_FILE,
                            OP_OR_W_WITH_FILE, OP_ROTATE_LEFT, OP_ROTATE_RIGHT};
   logic [13:0] ctl [8] = '{14'h2123, 14'h2A45, 14'h3256, 14'h3400, 14'h0008, 14'h0009, 14'h000A, 14'h000B};
   int          bad_count, num_checks, offs = 2; // done shows two samples after cycles*4
   bod_decoder i_bod_decoder (.sys_clk_i, .rst_n_i, .instr_i, .instr_valid_i, .file_rdata_i, .w_i, .carry_i,
      .fsr0_i, .fsr1_i, .skip_cond_i, .instr_ready_o, .phase_o, .file_rd_o, .file_wr_o, .file_addr_o,
      .file_wdata_o, .w_wr_o, .w_wdata_o, .flags_wr_o, .flags_mask_o, .flags_o, .bit_sel_o, .fsr_index_o,
      .literal_o, .flow_change_o, .illegal_o, .done_o, .cycles_o);
   bod_file_model i_bod_file_model (.sys_clk_i, .file_rd_i(file_rd_o), .file_wr_i(file_wr_o), .w_wr_i(w_wr_o),
      .flags_wr_i(flags_wr_o), .file_addr_i(file_addr_o), .file_wdata_i(file_wdata_o), .w_wdata_i(w_wdata_o),
      .flags_mask_i(flags_mask_o), .flags_i(flags_o), .file_rdata_o(file_rdata_i), .w_o(w_i), .carry_o(carry_i));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   task automatic close_out();
      if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : close_out
   // issue one word, wait for done, compare cycle count and done delay
   task automatic run(input logic [13:0] word, input logic sk, input int xc);
      int n;
      n = 0;
      @(posedge sys_clk_i);
      instr_i       <= word;
      instr_valid_i <= 1'b1;
      skip_cond_i   <= sk;
      @(negedge sys_clk_i);
      while (instr_ready_o !== 1'b1 && n < 20)
      begin
         @(negedge sys_clk_i);
         n++;
      end
      check("ready", 16'(instr_ready_o), 16'h0001);
      @(posedge sys_clk_i);
      instr_valid_i <= 1'b0;
      n = 0;
      while (done_o !== 1'b1 && n < 40)
      begin
         @(negedge sys_clk_i);
         n++;
         if (n == 2)
         begin
            addr_seen = file_addr_o;
            bit_seen  = bit_sel_o;
         end
      end
      check("done", 16'(done_o), 16'h0001);
      check("illegal", 16'(illegal_o), 16'h0000);
      n = n - 4 * int'(cycles_o);
      check("cycles", 16'(cycles_o), 16'(xc));
      check("done delay", 16'(n), 16'(offs));
      repeat (2) @(negedge sys_clk_i);
   endtask : run
   // preload operands, run one byte operation, compare against the reference
   task automatic byte_op(input logic [5:0] op, input logic d, input logic [6:0] a, input int xc);
      logic [7:0] f, w;
      logic [8:0] s;
      logic [2:0] old, m, fl;
      logic       dc, cin;
      f = 8'(rnd());
      w = 8'(rnd());
      old = 3'(rnd());
      cin = (op == OP_ADD_W_CARRY_TO_FILE) & old[0];
      i_bod_file_model.file_mem[a] = f;
      i_bod_file_model.w_reg = w;
      i_bod_file_model.flag_reg = old;
      dc = (5'(f[3:0]) + 5'(w[3:0]) + 5'(cin)) > 5'h0F;
      s = 9'(f) + 9'(w) + 9'(cin);
      m = 3'b111;
      if (op == OP_AND_W_WITH_FILE) s = {1'b0, f & w};
      if (op == OP_OR_W_WITH_FILE) s = {1'b0, f | w};
      if (op == OP_ROTATE_LEFT) s = {f, old[0]};
      if (op == OP_ROTATE_RIGHT) s = {f[0], old[0], f[7:1]};
      if (op == OP_AND_W_WITH_FILE || op == OP_OR_W_WITH_FILE) m = 3'b100;
      if (op == OP_ROTATE_LEFT || op == OP_ROTATE_RIGHT) m = 3'b001;
      fl = {s[7:0] == 8'h00, dc, s[8]};
      run({op, d, a}, 1'b0, xc);
      check("flags", 16'(i_bod_file_model.flag_reg), 16'((old & ~m) | (fl & m)));
      check("mask", 16'(flags_mask_o), 16'(m));
      check("w", 16'(i_bod_file_model.w_reg), 16'(d ? w : s[7:0]));
      check("file", 16'(i_bod_file_model.file_mem[a]), 16'(d ? s[7:0] : f));
      check("addr", 16'(addr_seen), 16'(a));
   endtask : byte_op
   initial
   begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end
   // watchdog sized well beyond the expected run length
   initial
   begin
      #(20 * 20000);
      bad_count++;
      close_out();
   end
   initial
   begin : main
      logic [7:0] k;
      logic       sk;
      rst_n_i = 1'b0;
      instr_valid_i = 1'b0;
      skip_cond_i = 1'b0;
      instr_i = 14'h0000;
      fsr0_i = 16'h0000;
      fsr1_i = 16'h0000;
      repeat (16) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 24; i++) byte_op(ops[i % 6], i[0], 7'h02 + 7'(rnd() % 126), 1);
      for (int i = 0; i < 8; i++)
      begin
         @(posedge sys_clk_i);
         fsr0_i <= {i[1], 15'(rnd())};
         fsr1_i <= {i[2], 15'(rnd())};
         byte_op(OP_ADD_W_TO_FILE, i[0], 7'(i[0]), 1 + int'(i[0] ? i[2] : i[1]));
         check("index", 16'(fsr_index_o), 16'(i[0]));
      end
      for (int i = 0; i < 4; i++)
      begin
         i_bod_file_model.w_reg = 8'(rnd()) | 8'h01;
         run(14'h0100 | 14'(i), 1'b0, 1);
         check("clear w", 16'(i_bod_file_model.w_reg), 16'h0000);
      end
      for (int i = 0; i < 8; i++)
      begin
         k = 8'(rnd());
         run(ctl[i] | ((i == 3) ? 14'(k) : 14'h0000), 1'b0, 2);
         check("flow", 16'(flow_change_o), 16'h0001);
         if (i == 3) check("literal", 16'(literal_o), 16'(k));
      end
      for (int i = 0; i < 16; i++)
      begin
         sk = 1'(rnd() % 2);
         run({3'b011, i[0], i[2:0], 7'h02 + 7'(rnd() % 126)}, sk, 1 + int'(sk));
         check("bit", 16'(bit_seen), 16'(i[2:0]));
         check("skip flow", 16'(flow_change_o), 16'(sk));
      end
      close_out();
   end
endmodule : testbench
bind bod_decoder bod_decoder_asserts i_bod_decoder_asserts (.sys_clk_i, .rst_n_i, .instr_valid_i, .instr_ready_o,
   .phase_o, .file_rd_o, .file_wr_o, .w_wr_o, .flags_wr_o, .flow_change_o, .done_o, .cycles_o);
